// ==== ufpc_cpu_model.sv ====
`timescale 1ns/100ps
module ufpc_cpu_model
    import ufpc_pkg::*;
(
    input wire logic clk,
    output logic instr_strobe,
    output logic fcr_wr,
    output logic [7:0] fcr_wdata,
    output ufpc_pkg::ufpc_xwr_t xwr,
    output ufpc_pkg::ufpc_crd_t crd
);
    // ****************************************************************
    // Instruction issue: 0 other, 1 control write, 2 data write, 3 read
    // ****************************************************************
    initial begin
        instr_strobe = 1'b0;
        fcr_wr = 1'b0;
        fcr_wdata = 8'h00;
        xwr = '0;
        crd = '0;
    end
    // No interrupt entry: only issued instructions ever run
    task automatic issue(input int k, input logic [15:0] a,
        input logic [7:0] d);
        @(posedge clk);
        #1;
        instr_strobe = 1'b1;
        fcr_wr = (k == 1);
        fcr_wdata = d;
        xwr = '{k == 2, a, d};
        crd = '{k == 3, a};
        @(posedge clk);
        #1;
        instr_strobe = 1'b0;
        fcr_wr = 1'b0;
        // Released lines flip so no stale value is mistaken for data
        fcr_wdata = ~d;
        xwr = '{1'b0, ~a, ~d};
        crd = '{1'b0, ~a};
    endtask : issue
endmodule : ufpc_cpu_model

// ==== ufpc_ctrl.sv ====
`timescale 1ns/100ps
module ufpc_ctrl
    import ufpc_pkg::*;
#(
    parameter int PROG_CYC = ufpc_pkg::PROG_CYCLES,
    parameter logic [7:0] BOOT_FILL = 8'hFF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire ufpc_pkg::ufpc_exec_t exec_space,
    input wire logic instr_strobe,
    input wire logic fcr_wr,
    input wire logic [7:0] fcr_wdata,
    output logic [7:0] fcr_rdata,
    input wire logic boot_map_bit,
    input wire logic external_ram_select,
    input wire ufpc_pkg::ufpc_xwr_t xwr,
    output logic xwr_to_latch,
    output logic xwr_to_xram,
    input wire ufpc_pkg::ufpc_crd_t crd,
    output logic [7:0] crd_data,
    output logic crd_hit,
    output logic program_in_progress,
    output logic [7:0] security_byte,
    output logic launch_refused
);
    import ufpc_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_PROG
    } ufpc_st_t;

    typedef struct packed {
        ufpc_st_t st;
        logic [3:0] key;
        logic lmap;
        logic [1:0] sel;
        logic armed;
        logic [PAGE_AW-1:0] page;
        logic [PAGE_AW-1:0] tgt_page;
        ufpc_sel_t tgt;
        logic [BYTE_AW-1:0] idx;
        logic [15:0] cnt;
        logic [7:0] sec;
        logic [7:0] rdata;
        logic hit;
        logic refused;
    } ufpc_state_t;

    ufpc_state_t s_q, s_d;

    logic [7:0] user_mem [ARRAY_BYTES];
    logic [7:0] extra_row_mem [PAGE_BYTES];
    logic [7:0] boot_mem [2**BOOT_AW];

    logic cl_wr;
    logic cl_clear;
    logic [7:0] cl_rdata;
    logic cl_loaded;
    logic walk_wr;
    logic walk_last;
    logic [15:0] prog_cnt;
    logic [3:0] key_in;
    logic key_second_ok;
    logic launch_ok;
    logic rd_boot;
    logic rd_extra_row;
    logic rd_sec;
    logic rd_user;

    // Counter is 16 bits wide, so PROG_CYC above 65535 is cut short
    assign prog_cnt = 16'(PROG_CYC);

    // ****************************************************************
    // Launch key decode
    // ****************************************************************
    assign key_in = fcr_wdata[KEY_HI:KEY_LO];
    // Second key only counts straight after an armed first key
    assign key_second_ok = fcr_wr && s_q.armed && key_in == KEY_SECOND &&
                           s_q.st == ST_IDLE;
    // Only code running from boot flash may start a real operation
    assign launch_ok = key_second_ok && exec_space == EXEC_BOOT &&
                       fcr_wdata[SEL_HI:SEL_LO] != SEL_RSVD;

    // ****************************************************************
    // Code-space read decode
    // ****************************************************************
    // Boot flash only answers code that itself runs from boot flash
    assign rd_boot = boot_map_bit && crd.addr >= BOOT_BASE &&
                     exec_space == EXEC_BOOT;
    // Security byte shadows user byte 0000h, and extra row answers from FF80h up, each only when selected
    assign rd_extra_row = s_q.sel == SEL_EXTRA_ROW && crd.addr >= EXTRA_ROW_BASE;
    assign rd_sec = s_q.sel == SEL_SEC && crd.addr == SEC_ADDR;
    assign rd_user = crd.addr <= USER_TOP && s_q.sel != SEL_RSVD;

    // ****************************************************************
    // Data-space write steering
    // ****************************************************************
    // Latch load below 8000h, or from FF80h up with the extra row selected; external code gets none
    always_comb begin
        xwr_to_latch = xwr.wr && s_q.lmap && !xwr.addr[15] &&
                       exec_space != EXEC_EXT && s_q.st == ST_IDLE;
        if (xwr.wr && s_q.lmap && s_q.sel == SEL_EXTRA_ROW &&
            xwr.addr >= EXTRA_ROW_BASE && exec_space != EXEC_EXT &&
            s_q.st == ST_IDLE) begin
            xwr_to_latch = 1'b1;
        end
        // Latch map blocks the external RAM write; external_ram_select is never used
        xwr_to_xram = xwr.wr && !xwr_to_latch && !s_q.lmap;
    end
    assign cl_wr = xwr_to_latch;
    assign walk_wr = (s_q.st == ST_PROG) && cl_loaded;
    assign walk_last = (s_q.idx == BYTE_AW'(PAGE_BYTES - 1));
    assign cl_clear = (s_q.st == ST_PROG) && s_q.cnt == 16'h0000 &&
                      walk_last;

    ufpc_latch_buf #(
        .DEPTH(PAGE_BYTES),
        .AW(BYTE_AW)
    ) u_latch (
        .clk(clk),
        .resetn(resetn),
        .wr(cl_wr),
        .waddr(xwr.addr[BYTE_AW-1:0]),
        .wdata(xwr.wdata),
        .clear(cl_clear),
        .raddr(s_q.idx),
        .rdata(cl_rdata),
        .rloaded(cl_loaded)
    );

    // ****************************************************************
    // Arrays; boot flash has no write port at all
    // ****************************************************************
    // Walk writes each loaded byte once: erase then program in one step
    // Plain always: the power-up fill below also writes these arrays
    always @(posedge clk) begin
        if (walk_wr && s_q.cnt == 16'h0000) begin
            if (s_q.tgt == SEL_USER) begin
                user_mem[{s_q.tgt_page, s_q.idx}] <= cl_rdata;
            end else if (s_q.tgt == SEL_EXTRA_ROW) begin
                extra_row_mem[s_q.idx] <= cl_rdata;
            end
        end
    end

    // Flash powers up erased; contents survive resetn like real cells
    initial begin
        for (int i = 0; i < ARRAY_BYTES; i++) begin
            user_mem[i] = ERASED;
        end
        for (int i = 0; i < PAGE_BYTES; i++) begin
            extra_row_mem[i] = ERASED;
        end
        for (int i = 0; i < 2**BOOT_AW; i++) begin
            boot_mem[i] = BOOT_FILL;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.refused = 1'b0;
        s_d.hit = 1'b0;
        // Any instruction other than a control register write disarms
        if (instr_strobe && !fcr_wr) begin
            s_d.armed = 1'b0;
        end
        if (xwr_to_latch) begin
            s_d.page = xwr.addr[ARRAY_AW-1:BYTE_AW];
        end
        if (fcr_wr) begin
            s_d.key = key_in;
            s_d.lmap = fcr_wdata[LMAP_BIT];
            s_d.sel = fcr_wdata[SEL_HI:SEL_LO];
            s_d.armed = (key_in == KEY_FIRST);
        end
        if (key_second_ok) begin
            s_d.armed = 1'b0;
            s_d.refused = !launch_ok;
        end
        if (launch_ok) begin
            s_d.st = ST_ERASE;
            s_d.tgt = ufpc_sel_t'(fcr_wdata[SEL_HI:SEL_LO]);
            s_d.tgt_page = s_d.page;
            s_d.cnt = prog_cnt;
            s_d.idx = '0;
        end
        case (s_q.st)
            ST_IDLE: begin
                if (xwr_to_latch && s_q.sel == SEL_SEC &&
                    xwr.addr == SEC_ADDR) begin
                    s_d.idx = '0;
                end
            end
            ST_ERASE: begin
                // Erase half of the timed interval
                if (s_q.cnt <= (prog_cnt >> 1)) begin
                    s_d.st = ST_PROG;
                    s_d.cnt = s_q.cnt;
                end else begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end
            end
            ST_PROG: begin
                // Walk one latch byte per cycle once the interval has run
                if (s_q.cnt != 16'h0000) begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end else begin
                    if (s_q.tgt == SEL_SEC && s_q.idx == '0 &&
                        cl_loaded) begin
                        // Only the upper nibble is ever changed here
                        s_d.sec = {cl_rdata[7:4] & SEC_SW_MASK,
                                   s_q.sec[3:0]};
                    end
                    s_d.idx = s_q.idx + BYTE_AW'(1);
                    if (walk_last) begin
                        s_d.st = ST_IDLE;
                        s_d.idx = '0;
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        // Code-space reads
        if (crd.rd) begin
            s_d.hit = 1'b1;
            s_d.rdata = ERASED;
            if (rd_boot) begin
                s_d.rdata = boot_mem[crd.addr[BOOT_AW-1:0]];
            end else if (exec_space == EXEC_EXT) begin
                s_d.hit = 1'b0;
            end else if (rd_extra_row) begin
                s_d.rdata = extra_row_mem[crd.addr[BYTE_AW-1:0]];
            end else if (rd_sec) begin
                s_d.rdata = s_q.sec;
            end else if (rd_user) begin
                s_d.rdata = user_mem[crd.addr[ARRAY_AW-1:0]];
            end else begin
                s_d.hit = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{st: ST_IDLE, key: 4'h0, lmap: 1'b0, sel: 2'b00,
                     armed: 1'b0, page: '0, tgt_page: '0, tgt: SEL_USER,
                     idx: '0, cnt: 16'h0000, sec: SEC_RESET,
                     rdata: 8'h00, hit: 1'b0, refused: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign program_in_progress = (s_q.st != ST_IDLE);
    assign fcr_rdata = {s_q.key, s_q.lmap, s_q.sel,
                        program_in_progress};
    assign crd_data = s_q.rdata;
    assign crd_hit = s_q.hit;
    assign security_byte = s_q.sec;
    assign launch_refused = s_q.refused;
endmodule : ufpc_ctrl

// ==== ufpc_ctrl_checker.sv ====
`timescale 1ns/100ps
module ufpc_ctrl_checker
    import ufpc_pkg::*;
#(
    parameter int PROG_CYC = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire ufpc_pkg::ufpc_exec_t exec_space,
    input wire logic fcr_wr,
    input wire logic [7:0] fcr_wdata,
    input wire logic [7:0] fcr_rdata,
    input wire logic boot_map_bit,
    input wire ufpc_pkg::ufpc_xwr_t xwr,
    input wire logic xwr_to_latch,
    input wire logic xwr_to_xram,
    input wire ufpc_pkg::ufpc_crd_t crd,
    input wire logic crd_hit,
    input wire logic program_in_progress
);
    import ufpc_pkg::*;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [15:0] run_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_q <= 16'h0000;
        end else begin
            run_q <= program_in_progress ? run_q + 16'h0001 : 16'h0000;
        end
    end
    chk_launch_src: assert property ($rose(program_in_progress) |->
        $past(fcr_wr) && $past(fcr_wdata[7:4]) == 4'hA
        && $past(exec_space) == EXEC_BOOT) else $error("bad launch");
    chk_prog_length: assert property ($fell(program_in_progress) |->
        run_q >= PROG_CYC) else $error("busy too short");
    chk_busy_bit: assert property (fcr_rdata[0] == program_in_progress)
        else $error("busy bit");
    chk_busy_hold: assert property ($rose(fcr_rdata[0]) |->
        fcr_rdata[0] [*8]) else $error("busy dropped early");
    chk_fcr_fields: assert property (fcr_wr && !program_in_progress |=>
        fcr_rdata[3:1] == $past(fcr_wdata[3:1])) else $error("fcr fields");
    chk_user_refused: assert property (fcr_wr && fcr_wdata[7:4] == 4'hA
        && exec_space != EXEC_BOOT && !program_in_progress |=>
        !program_in_progress) else $error("launch outside boot");
    chk_latch_wins: assert property (xwr.wr && fcr_rdata[3]
        && xwr.addr <= 16'h7FFF && exec_space == EXEC_BOOT
        && !program_in_progress |-> xwr_to_latch && !xwr_to_xram)
        else $error("latch load missed");
    chk_ext_noload: assert property (xwr.wr && exec_space == EXEC_EXT
        |-> !xwr_to_latch) else $error("ext latch load");
    chk_ext_noread: assert property (crd.rd && exec_space == EXEC_EXT
        |=> !crd_hit) else $error("ext read hit");
    chk_boot_map: assert property (crd.rd && exec_space == EXEC_BOOT
        && boot_map_bit && crd.addr >= 16'hF800 && fcr_rdata[2:1] == 2'b00
        |=> crd_hit) else $error("boot map miss");
    chk_user_read: assert property (crd.rd && exec_space != EXEC_EXT
        && fcr_rdata[2:1] == 2'b00 && crd.addr <= 16'h7FFF
        && !program_in_progress |=> crd_hit) else $error("user read miss");
endmodule : ufpc_ctrl_checker

bind ufpc_ctrl ufpc_ctrl_checker #(.PROG_CYC(PROG_CYC)) u_chk (.clk(clk),
    .resetn(resetn), .exec_space(exec_space), .fcr_wr(fcr_wr),
    .fcr_wdata(fcr_wdata), .fcr_rdata(fcr_rdata), .boot_map_bit(boot_map_bit),
    .xwr(xwr), .xwr_to_latch(xwr_to_latch), .xwr_to_xram(xwr_to_xram),
    .crd(crd), .crd_hit(crd_hit), .program_in_progress(program_in_progress));

// ==== ufpc_latch_buf.sv ====
`timescale 1ns/100ps
module ufpc_latch_buf
    import ufpc_pkg::*;
#(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wr,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic clear,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata,
    output logic rloaded
);
    import ufpc_pkg::*;

    // ****************************************************************
    // One page of column latches with per-byte loaded marks
    // ****************************************************************
    logic [7:0] mem [DEPTH];
    logic [DEPTH-1:0] loaded_q;

    always_ff @(posedge clk) begin
        if (wr) begin
            mem[waddr] <= wdata;
        end
    end

    // Set wins over clear so a load in the final cycle is kept
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loaded_q <= '0;
        end else begin
            if (clear) begin
                loaded_q <= '0;
            end
            if (wr) begin
                loaded_q[waddr] <= 1'b1;
            end
        end
    end

    assign rdata = mem[raddr];
    assign rloaded = loaded_q[raddr];
endmodule : ufpc_latch_buf

// ==== ufpc_pkg.sv ====
package ufpc_pkg;
    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_COUNT = 256;
    localparam int BYTE_AW = 7;
    localparam int PAGE_AW = 8;
    localparam int ARRAY_AW = 15;
    localparam int ARRAY_BYTES = 32768;
    localparam logic [15:0] EXTRA_ROW_BASE = 16'hFF80;
    localparam logic [15:0] BOOT_BASE = 16'hF800;
    localparam logic [15:0] USER_TOP = 16'h7FFF;
    localparam logic [15:0] SEC_ADDR = 16'h0000;
    localparam int BOOT_AW = 11;
    localparam logic [7:0] SEC_RESET = 8'h00;
    localparam logic [7:0] ERASED = 8'hFF;
    // ****************************************************************
    // Flash control register layout
    // ****************************************************************
    localparam int KEY_HI = 7;
    localparam int KEY_LO = 4;
    localparam int LMAP_BIT = 3;
    localparam int SEL_HI = 2;
    localparam int SEL_LO = 1;
    localparam int BUSY_BIT = 0;
    localparam logic [7:0] FCR_RESET = 8'h00;
    localparam logic [3:0] KEY_FIRST = 4'h5;
    localparam logic [3:0] KEY_SECOND = 4'hA;
    localparam logic [3:0] SEC_SW_MASK = 4'hF;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 40;
    localparam int PROG_TIME_US = 2;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {
        SEL_USER,
        SEL_EXTRA_ROW,
        SEL_SEC,
        SEL_RSVD
    } ufpc_sel_t;

    typedef enum logic [1:0] {
        EXEC_USER,
        EXEC_BOOT,
        EXEC_EXT
    } ufpc_exec_t;

    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ufpc_xwr_t;

    typedef struct packed {
        logic rd;
        logic [15:0] addr;
    } ufpc_crd_t;
endpackage : ufpc_pkg

// ==== user_flash_program_control_bench.sv ====
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
    fail_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module user_flash_program_control_bench;
    import ufpc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic boot_map_bit = 1'b0;
    logic external_ram_select = 1'b1;
    ufpc_exec_t exec_space = EXEC_BOOT;
    logic fcr_wr, instr_strobe, xwr_to_latch, xwr_to_xram, crd_hit;
    logic program_in_progress, launch_refused;
    logic [7:0] fcr_wdata, fcr_rdata, crd_data, security_byte, d;
    logic [7:0] img [128];
    logic [7:0] pg;
    ufpc_xwr_t xwr;
    ufpc_crd_t crd;
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    ufpc_cpu_model cpu (.clk(clk), .instr_strobe(instr_strobe),
        .fcr_wr(fcr_wr), .fcr_wdata(fcr_wdata), .xwr(xwr), .crd(crd));
    ufpc_ctrl #(.PROG_CYC(8)) dut (.clk(clk), .resetn(resetn),
        .exec_space(exec_space), .instr_strobe(instr_strobe),
        .fcr_wr(fcr_wr), .fcr_wdata(fcr_wdata), .fcr_rdata(fcr_rdata),
        .boot_map_bit(boot_map_bit), .external_ram_select(external_ram_select),
        .xwr(xwr), .xwr_to_latch(xwr_to_latch), .xwr_to_xram(xwr_to_xram),
        .crd(crd), .crd_data(crd_data), .crd_hit(crd_hit),
        .program_in_progress(program_in_progress),
        .security_byte(security_byte), .launch_refused(launch_refused));
    task automatic end_sim;
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    // Only the upper nibble of the security byte is software-writable
    function automatic logic [7:0] sec_exp(input logic [7:0] old,
        input logic [7:0] ld);
        return {ld[7:4], old[3:0]};
    endfunction : sec_exp
    // Ceiling well above the longest legal run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic launch(input logic [3:0] sel, input logic st,
        input logic eb);
        cpu.issue(1, 16'h0000, {4'h5, sel});
        `CHK("key", {4'h5, sel[3:1], 1'b0}, fcr_rdata)
        if (st) cpu.issue(0, 16'h0000, 8'h00);
        cpu.issue(1, 16'h0000, {4'hA, sel});
        `CHK("busy", eb, program_in_progress)
        if (!st) `CHK("refused", !eb, launch_refused)
        for (int i = 0; i < 400 && program_in_progress !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        `CHK("idle", 1'b0, program_in_progress)
    endtask : launch
    task automatic rd(input logic [15:0] a, input logic h, input logic [7:0] e);
        cpu.issue(3, a, 8'h00);
        `CHK("hit", h, crd_hit)
        if (h) `CHK("rdata", e, crd_data)
    endtask : rd
    initial begin
        d = $urandom(32'h692a);
        repeat (16) @(posedge clk);
        #1;
        resetn = 1'b1;
        `CHK("fcr reset", 8'h00, fcr_rdata)
        `CHK("sec reset", 8'h00, security_byte)
        pg = $urandom;
        foreach (img[i]) img[i] = 8'hFF;
        for (int r = 0; r < 2; r++) begin
            cpu.issue(1, 16'h0000, 8'h08);
            img[5] = $urandom;
            cpu.issue(2, {1'b0, pg ^ 8'h01, 7'd5}, img[5]);
            for (int n = 0; n < (r == 0 ? 1 : 1 + $urandom % 40); n++) begin
                int ix;
                ix = (n == 0) ? 127 : $urandom % 128;
                img[ix] = $urandom;
                cpu.issue(2, {1'b0, pg, ix[6:0]}, img[ix]);
            end
            launch(4'h0, 1'b0, 1'b1);
            foreach (img[i]) rd({1'b0, pg, i[6:0]}, 1'b1, img[i]);
        end
        rd({1'b0, pg ^ 8'h01, 7'd5}, 1'b1, 8'hFF);
        exec_space = EXEC_USER;
        launch(4'h0, 1'b0, 1'b0);
        exec_space = EXEC_BOOT;
        launch(4'h6, 1'b0, 1'b0);
        launch(4'h0, 1'b1, 1'b0);
        cpu.issue(1, 16'h0000, 8'h0A);
        for (int i = 0; i < 4; i++) begin
            img[i] = $urandom;
            cpu.issue(2, 16'hFF80 + 16'(i * 41), img[i]);
        end
        launch(4'h2, 1'b0, 1'b1);
        cpu.issue(1, 16'h0000, 8'h02);
        for (int i = 0; i < 4; i++) rd(16'hFF80 + 16'(i * 41), 1'b1, img[i]);
        cpu.issue(1, 16'h0000, 8'h0C);
        `CHK("fcr", 8'h0C, fcr_rdata)
        cpu.issue(2, 16'h0000, d);
        launch(4'h4, 1'b0, 1'b1);
        `CHK("sec", sec_exp(SEC_RESET, d), security_byte)
        cpu.issue(1, 16'h0000, 8'h04);
        rd(16'h0000, 1'b1, sec_exp(SEC_RESET, d));
        cpu.issue(1, 16'h0000, 8'h08);
        exec_space = EXEC_EXT;
        cpu.issue(2, 16'h0010, d);
        rd(16'h0010, 1'b0, 8'h00);
        exec_space = EXEC_USER;
        boot_map_bit = 1'b1;
        cpu.issue(1, 16'h0000, 8'h00);
        rd(16'hF800, 1'b0, 8'h00);
        exec_space = EXEC_BOOT;
        rd(16'hF800, 1'b1, 8'hFF);
        end_sim();
    end
endmodule : user_flash_program_control_bench
